// file: rtl/irqfe_top.v
// Interrupt flag register 3 and enable register 0 with register port
//
// The register addresses and the plain strobed port were left to the implementer.
`include "irqfe_map.vh"
module irqfe_top (
    input  wire        i_mclk,
    input  wire        i_rst_n,
    input  wire [3:0]  i_addr,
    input  wire [15:0] i_wdata,
    input  wire        i_wr,
    input  wire        i_rd,
    output wire [15:0] o_rdata,
    input  wire        i_can2_tx_req,
    input  wire        i_can1_tx_req,
    input  wire        i_dma_ch7_done,
    input  wire        i_dma_ch6_done,
    input  wire        i_uart2_error,
    input  wire        i_uart1_error,
    input  wire [14:0] i_flag_in_other,
    output wire [15:0] o_flags3_req,
    output wire [14:0] o_enables0
);
    // -----------------------------
    // Address decode
    // -----------------------------
    function sel;
        input [3:0] a;
        input [3:0] off;
        begin
            sel = (a == off);
        end
    endfunction

    // True for either register offset; every other offset reads back zero
    function mapped;
        input [3:0] a;
        begin
            mapped = sel(a, `IRQFE_OFF_FLAGS3) | sel(a, `IRQFE_OFF_ENABLES0);
        end
    endfunction

    wire        wr_flags;
    wire        wr_en;
    wire [15:0] set_vec;
    wire [15:0] flags;
    wire [15:0] enables;
    wire [15:0] gated;
    reg  [15:0] rdata_q;
    wire        rd_flags;
    wire        rd_en;
    wire        rd_hit;
    wire [15:0] flags_view;
    wire [15:0] enables_view;
    wire [15:0] rd_word;

    // Named flag fields
    wire        can2_tx_request_flag;
    wire        can1_tx_request_flag;
    wire        dma_ch7_done_flag;
    wire        dma_ch6_done_flag;
    wire        uart2_error_flag;
    wire        uart1_error_flag;

    // Named enable fields
    wire        dma_ch1_done_enable;
    wire        adc1_done_enable;
    wire        uart1_tx_enable_irq;
    wire        uart1_rx_enable_irq;
    wire        spi1_event_enable;
    wire        spi1_error_enable;
    wire        timer3_irq_enable;
    wire        timer2_irq_enable;
    wire        compare2_irq_enable;
    wire        capture2_irq_enable;
    wire        dma_ch0_done_enable;
    wire        timer1_irq_enable;
    wire        compare1_irq_enable;
    wire        capture1_irq_enable;
    wire        ext_irq0_enable;

    // Requests passed on to the priority logic
    wire        dma_ch1_done_req;
    wire        adc1_done_req;
    wire        uart1_tx_req;
    wire        uart1_rx_req;
    wire        spi1_event_req;
    wire        spi1_error_req;
    wire        timer3_req;
    wire        timer2_req;
    wire        compare2_req;
    wire        capture2_req;
    wire        dma_ch0_done_req;
    wire        timer1_req;
    wire        compare1_req;
    wire        capture1_req;
    wire        ext_irq0_req;

    assign wr_flags = i_wr & sel(i_addr, `IRQFE_OFF_FLAGS3);
    assign wr_en    = i_wr & sel(i_addr, `IRQFE_OFF_ENABLES0);
    assign rd_flags = i_rd & sel(i_addr, `IRQFE_OFF_FLAGS3);
    assign rd_en    = i_rd & sel(i_addr, `IRQFE_OFF_ENABLES0);
    assign rd_hit   = i_rd & mapped(i_addr);

    // -----------------------------
    // Source mapping
    // -----------------------------
    assign set_vec[15:8]                = 8'h00;
    assign set_vec[`IRQFE_BIT_CAN2_TX]  = i_can2_tx_req;
    assign set_vec[`IRQFE_BIT_CAN1_TX]  = i_can1_tx_req;
    assign set_vec[`IRQFE_BIT_DMA7]     = i_dma_ch7_done;
    assign set_vec[`IRQFE_BIT_DMA6]     = i_dma_ch6_done;
    assign set_vec[3]                   = 1'b0;
    assign set_vec[`IRQFE_BIT_UART2_ERR] = i_uart2_error;
    assign set_vec[`IRQFE_BIT_UART1_ERR] = i_uart1_error;
    assign set_vec[0]                   = 1'b0;

    irqfe_flag_bank u_flags (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_wr    (wr_flags),
        .i_wdata (i_wdata),
        .i_set   (set_vec),
        .o_flags (flags)
    );

    // Enable bits' flags live in other flag registers, brought in as a vector
    irqfe_enable_bank u_en (
        .i_mclk    (i_mclk),
        .i_rst_n   (i_rst_n),
        .i_wr      (wr_en),
        .i_wdata   (i_wdata),
        .i_flags   ({1'b0, i_flag_in_other}),
        .o_enables (enables),
        .o_gated   (gated)
    );

    // -----------------------------
    // Flag fields
    // -----------------------------
    assign can2_tx_request_flag = flags[`IRQFE_BIT_CAN2_TX];
    assign can1_tx_request_flag = flags[`IRQFE_BIT_CAN1_TX];
    assign dma_ch7_done_flag    = flags[`IRQFE_BIT_DMA7];
    assign dma_ch6_done_flag    = flags[`IRQFE_BIT_DMA6];
    assign uart2_error_flag     = flags[`IRQFE_BIT_UART2_ERR];
    assign uart1_error_flag     = flags[`IRQFE_BIT_UART1_ERR];

    // Flag 3 sources have their enables elsewhere; exported raw
    assign o_flags3_req = flags;

    // -----------------------------
    // Enable fields
    // -----------------------------
    assign dma_ch1_done_enable = enables[`IRQFE_BIT_DMA1_EN];
    assign adc1_done_enable    = enables[`IRQFE_BIT_ADC1_EN];
    assign uart1_tx_enable_irq = enables[`IRQFE_BIT_UART1TX_EN];
    assign uart1_rx_enable_irq = enables[`IRQFE_BIT_UART1RX_EN];
    assign spi1_event_enable   = enables[`IRQFE_BIT_SPI1EV_EN];
    assign spi1_error_enable   = enables[`IRQFE_BIT_SPI1ER_EN];
    assign timer3_irq_enable   = enables[`IRQFE_BIT_TMR3_EN];
    assign timer2_irq_enable   = enables[`IRQFE_BIT_TMR2_EN];
    assign compare2_irq_enable = enables[`IRQFE_BIT_CMP2_EN];
    assign capture2_irq_enable = enables[`IRQFE_BIT_CAP2_EN];
    assign dma_ch0_done_enable = enables[`IRQFE_BIT_DMA0_EN];
    assign timer1_irq_enable   = enables[`IRQFE_BIT_TMR1_EN];
    assign compare1_irq_enable = enables[`IRQFE_BIT_CMP1_EN];
    assign capture1_irq_enable = enables[`IRQFE_BIT_CAP1_EN];
    assign ext_irq0_enable     = enables[`IRQFE_BIT_EXT0_EN];

    // -----------------------------
    // Gated requests
    // -----------------------------
    // Each request needs both its pending flag and its enable bit
    assign dma_ch1_done_req = gated[`IRQFE_BIT_DMA1_EN];
    assign adc1_done_req    = gated[`IRQFE_BIT_ADC1_EN];
    assign uart1_tx_req     = gated[`IRQFE_BIT_UART1TX_EN];
    assign uart1_rx_req     = gated[`IRQFE_BIT_UART1RX_EN];
    assign spi1_event_req   = gated[`IRQFE_BIT_SPI1EV_EN];
    assign spi1_error_req   = gated[`IRQFE_BIT_SPI1ER_EN];
    assign timer3_req       = gated[`IRQFE_BIT_TMR3_EN];
    assign timer2_req       = gated[`IRQFE_BIT_TMR2_EN];
    assign compare2_req     = gated[`IRQFE_BIT_CMP2_EN];
    assign capture2_req     = gated[`IRQFE_BIT_CAP2_EN];
    assign dma_ch0_done_req = gated[`IRQFE_BIT_DMA0_EN];
    assign timer1_req       = gated[`IRQFE_BIT_TMR1_EN];
    assign compare1_req     = gated[`IRQFE_BIT_CMP1_EN];
    assign capture1_req     = gated[`IRQFE_BIT_CAP1_EN];
    assign ext_irq0_req     = gated[`IRQFE_BIT_EXT0_EN];

    assign o_enables0 = {
        dma_ch1_done_req,
        adc1_done_req,
        uart1_tx_req,
        uart1_rx_req,
        spi1_event_req,
        spi1_error_req,
        timer3_req,
        timer2_req,
        compare2_req,
        capture2_req,
        dma_ch0_done_req,
        timer1_req,
        compare1_req,
        capture1_req,
        ext_irq0_req
    };

    // -----------------------------
    // Read-back words
    // -----------------------------
    assign flags_view = {
        8'h00,
        can2_tx_request_flag,
        can1_tx_request_flag,
        dma_ch7_done_flag,
        dma_ch6_done_flag,
        1'b0,
        uart2_error_flag,
        uart1_error_flag,
        1'b0
    };

    assign enables_view = {
        1'b0,
        dma_ch1_done_enable,
        adc1_done_enable,
        uart1_tx_enable_irq,
        uart1_rx_enable_irq,
        spi1_event_enable,
        spi1_error_enable,
        timer3_irq_enable,
        timer2_irq_enable,
        compare2_irq_enable,
        capture2_irq_enable,
        dma_ch0_done_enable,
        timer1_irq_enable,
        compare1_irq_enable,
        capture1_irq_enable,
        ext_irq0_enable
    };

    // Unmapped offsets select neither word and so read zero
    assign rd_word = ({16{rd_flags}} & flags_view) | ({16{rd_en}} & enables_view);

    // -----------------------------
    // Read port
    // -----------------------------
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_q <= 16'h0000;
        end else if (rd_hit) begin
            rdata_q <= rd_word;
        end else begin
            // Zero outside the reply cycle so stale data never lingers
            rdata_q <= 16'h0000;
        end
    end

    assign o_rdata = rdata_q;
endmodule // irqfe_top

// file: pkg/irqfe_map.vh
// Register offsets, field positions and reset values for the flag/enable slice
`ifndef IRQFE_MAP_VH
`define IRQFE_MAP_VH
`define IRQFE_ADDR_W          4
`define IRQFE_DATA_W          16
`define IRQFE_OFF_FLAGS3      4'h0
`define IRQFE_OFF_ENABLES0    4'h2
`define IRQFE_FLAGS3_RST      16'h0000
`define IRQFE_ENABLES0_RST    16'h0000
`define IRQFE_FLAGS3_MASK     16'h00F6
`define IRQFE_ENABLES0_MASK   16'h7FFF
`define IRQFE_BIT_CAN2_TX     7
`define IRQFE_BIT_CAN1_TX     6
`define IRQFE_BIT_DMA7        5
`define IRQFE_BIT_DMA6        4
`define IRQFE_BIT_UART2_ERR   2
`define IRQFE_BIT_UART1_ERR   1
`define IRQFE_BIT_DMA1_EN     14
`define IRQFE_BIT_ADC1_EN     13
`define IRQFE_BIT_UART1TX_EN  12
`define IRQFE_BIT_UART1RX_EN  11
`define IRQFE_BIT_SPI1EV_EN   10
`define IRQFE_BIT_SPI1ER_EN   9
`define IRQFE_BIT_TMR3_EN     8
`define IRQFE_BIT_TMR2_EN     7
`define IRQFE_BIT_CMP2_EN     6
`define IRQFE_BIT_CAP2_EN     5
`define IRQFE_BIT_DMA0_EN     4
`define IRQFE_BIT_TMR1_EN     3
`define IRQFE_BIT_CMP1_EN     2
`define IRQFE_BIT_CAP1_EN     1
`define IRQFE_BIT_EXT0_EN     0
`endif

// file: rtl/irqfe_flag_bank.v
// Sticky flag register bank with hardware set and software write
`include "irqfe_map.vh"
module irqfe_flag_bank (
    input  wire        i_mclk,
    input  wire        i_rst_n,
    input  wire        i_wr,
    input  wire [15:0] i_wdata,
    input  wire [15:0] i_set,
    output wire [15:0] o_flags
);
    reg  [15:0] flags_q;
    reg  [15:0] flags_d;

    // -----------------------------
    // Flag update
    // -----------------------------
    always @* begin
        flags_d = flags_q;
        if (i_wr) begin
            flags_d = i_wdata;
        end
        // Set beats a same-cycle software clear
        flags_d = (flags_d | i_set) & `IRQFE_FLAGS3_MASK;
    end

    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            flags_q <= `IRQFE_FLAGS3_RST;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign o_flags = flags_q;
endmodule // irqfe_flag_bank

// file: rtl/irqfe_enable_bank.v
// Enable register and request gating
`include "irqfe_map.vh"
module irqfe_enable_bank (
    input  wire        i_mclk,
    input  wire        i_rst_n,
    input  wire        i_wr,
    input  wire [15:0] i_wdata,
    input  wire [15:0] i_flags,
    output wire [15:0] o_enables,
    output wire [15:0] o_gated
);
    reg  [15:0] en_q;

    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            en_q <= `IRQFE_ENABLES0_RST;
        end else if (i_wr) begin
            en_q <= i_wdata & `IRQFE_ENABLES0_MASK;
        end
    end

    assign o_enables = en_q;
    // Forward only while flag and enable are both set
    assign o_gated   = i_flags & en_q;
endmodule // irqfe_enable_bank

// file: verification/irqfe_props.sv
// Port assertions for the flag and enable slice
module irqfe_props (
    input wire        i_mclk,
    input wire        i_rst_n,
    input wire [3:0]  i_addr,
    input wire        i_wr,
    input wire        i_rd,
    input wire [15:0] o_rdata,
    input wire        i_can2_tx_req,
    input wire        i_can1_tx_req,
    input wire        i_dma_ch7_done,
    input wire        i_dma_ch6_done,
    input wire        i_uart2_error,
    input wire        i_uart1_error,
    input wire [14:0] i_flag_in_other,
    input wire [15:0] o_flags3_req,
    input wire [14:0] o_enables0
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    a_unimpl_zero: assert property ((o_flags3_req & 16'hff09) == 16'h0000) else $error("spare flags");
    a_gate_sub: assert property ((o_enables0 & ~i_flag_in_other) == 15'h0000) else $error("gate");
    a_can_set: assert property (i_can1_tx_req |=> o_flags3_req[6]) else $error("can1");
    a_can2_set: assert property (i_can2_tx_req |=> o_flags3_req[7]) else $error("can2");
    a_dma_set: assert property (i_dma_ch7_done |=> o_flags3_req[5]) else $error("dma7");
    a_dma6_set: assert property (i_dma_ch6_done |=> o_flags3_req[4]) else $error("dma6");
    a_uart_set: assert property (i_uart1_error |=> o_flags3_req[1]) else $error("uart1");
    a_uart2_set: assert property (i_uart2_error |=> o_flags3_req[2]) else $error("uart2");
    a_rd_data: assert property (
        i_rd && i_addr == 4'h0 |=> o_rdata == $past(o_flags3_req)) else $error("read data");
    a_flag_hold: assert property (
        !i_wr && !(i_can2_tx_req || i_can1_tx_req || i_dma_ch7_done
        || i_dma_ch6_done || i_uart2_error || i_uart1_error) |=> $stable(o_flags3_req))
        else $error("flag hold");
    a_rd_en_spare: assert property (i_rd && i_addr == 4'h2 |=> !o_rdata[15])
        else $error("spare enable");
    a_rd_idle: assert property (!i_rd |=> o_rdata == 16'h0000) else $error("idle rdata");
    a_rd_unmapped: assert property (
        i_rd && i_addr != 4'h0 && i_addr != 4'h2 |=> o_rdata == 16'h0000) else $error("unmapped");
endmodule // irqfe_props
bind irqfe_top irqfe_props irqfe_props_inst (.*);

// file: verification/irqfe_src_model.sv
// Event source model: one fire request gives a one-cycle source pulse
module irqfe_src_model (
    input  wire        i_mclk,
    input  wire        i_rst_n,
    input  wire [5:0]  i_fire,
    output logic [5:0] o_src
);
    timeunit 1ns;
    timeprecision 1ps;
    always @(posedge i_mclk or negedge i_rst_n) o_src <= i_rst_n ? i_fire : 6'h00;
endmodule // irqfe_src_model

// file: verification/tb_top.sv
// Register-level bench for the flag and enable slice
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_mclk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [15:0] i_wdata = 16'h0000, o_rdata, o_flags3_req;
    logic [14:0] i_flag_in_other = 15'h0000, o_enables0;
    logic [5:0] fire = 6'h00;
    wire i_can2_tx_req, i_can1_tx_req, i_dma_ch7_done, i_dma_ch6_done, i_uart2_error, i_uart1_error;
    int n_fail = 0, check_count = 0, pos [6] = '{7, 6, 5, 4, 2, 1};
    always #5 i_mclk = ~i_mclk;
    initial begin
        repeat (20000) @(posedge i_mclk);
        n_fail++;
        wrap_up;
    end
    irqfe_src_model irqfe_src_model_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_fire(fire),
        .o_src({i_can2_tx_req, i_can1_tx_req, i_dma_ch7_done, i_dma_ch6_done, i_uart2_error,
        i_uart1_error}));
    irqfe_top irqfe_top_inst (.*);
    task automatic chk(input string w, input logic [15:0] s, input logic [15:0] e);
        check_count++;
        if (s !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", w, e, s);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_mclk);
        {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge i_mclk);
        {i_rd, i_addr} <= {1'b1, a};
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 chk("rdata", o_rdata, e);
    endtask
    task automatic wrap_up;
        $display("Checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        rd(4'h0, 16'h0000);
        rd(4'h2, 16'h0000);
        wr(4'h2, 16'hffff);
        rd(4'h2, 16'h7fff);
        wr(4'h0, 16'hffff);
        wr(4'h4, 16'h0000);
        rd(4'h4, 16'h0000);
        rd(4'h0, 16'h00f6);
        wr(4'h0, 16'h0000);
        i_flag_in_other <= 15'h7fff;
        for (int i = 0; i < 15; i++) begin
            wr(4'h2, 16'h0001 << i);
            #1 chk("gate", {1'b0, o_enables0}, 16'h0001 << i);
        end
        for (int k = 0; k < 6; k++) begin
            @(posedge i_mclk);
            fire <= 6'h20 >> k;
            @(posedge i_mclk);
            fire <= 6'h00;
            @(posedge i_mclk);
            #1 chk("flag", o_flags3_req, 16'h0001 << pos[k]);
            wr(4'h0, 16'h0000);
            rd(4'h0, 16'h0000);
        end
        // Source event and software clear in one cycle: the event must win
        @(posedge i_mclk);
        fire <= 6'h3f;
        @(posedge i_mclk);
        fire <= 6'h00;
        {i_wr, i_addr, i_wdata} <= {1'b1, 4'h0, 16'h0000};
        @(posedge i_mclk);
        i_wr <= 1'b0;
        #1 chk("set_wins", o_flags3_req, 16'h00f6);
        wr(4'h2, 16'h7fff);
        i_flag_in_other <= 15'h5555;
        #1 chk("gate_mix", {1'b0, o_enables0}, 16'h5555);
        @(posedge i_mclk);
        i_flag_in_other <= 15'h0000;
        #1 chk("gate_noflag", {1'b0, o_enables0}, 16'h0000);
        wr(4'h2, 16'h0000);
        i_flag_in_other <= 15'h7fff;
        #1 chk("gate_noen", {1'b0, o_enables0}, 16'h0000);
        // Mid-run reset with flags and enables set
        wr(4'h2, 16'h7fff);
        @(posedge i_mclk);
        i_rst_n <= 1'b0;
        #1 chk("rst_gate", {1'b0, o_enables0}, 16'h0000);
        chk("rst_flags", o_flags3_req, 16'h0000);
        repeat (2) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        rd(4'h0, 16'h0000);
        rd(4'h2, 16'h0000);
        wrap_up;
    end
endmodule // tb_top
